//--- rtl/mgmt_pkg.sv
// Constants and types for the pluggable module management timing block
package mgmt_pkg;
  // ****************************************
  // Time base and deadlines
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int RESET_MIN_US = 10;
  localparam int RESET_MIN_CYCLES = RESET_MIN_US * CLK_MHZ;
  localparam int INIT_LIMIT_MS = 2000;
  localparam int INIT_LIMIT_TICKS = INIT_LIMIT_MS * 1000 / TICK_US;
  localparam int INIT_MS = 1000;
  localparam int INIT_TICKS = INIT_MS * 1000 / TICK_US;
  localparam int WAKE_LIMIT_MS = 300;
  localparam int WAKE_LIMIT_TICKS = WAKE_LIMIT_MS * 1000 / TICK_US;
  localparam int WAKE_MS = 200;
  localparam int WAKE_TICKS = WAKE_MS * 1000 / TICK_US;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [7:0] STATUS_ADDR = 8'h02;
  localparam logic [7:0] FLAGS_ADDR = 8'h03;
  localparam logic [7:0] MASK_ADDR = 8'h04;
  localparam logic [7:0] CTRL_ADDR = 8'h05;
  localparam logic [7:0] STATE_ADDR = 8'h06;
  localparam int NOT_READY_BIT = 0;
  localparam int FLAG_RX_LOSS = 0;
  localparam int FLAG_TX_FAULT = 1;
  localparam int FLAG_AUX = 2;
  localparam int FLAG_INIT_DONE = 3;
  localparam int CTRL_PWR_OVR = 0;
  localparam int CTRL_PWR_SET = 1;
  localparam int CTRL_PIN_LASER_OFF = 2;
  localparam int CTRL_PIN_RXLOS = 3;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [6:0] SYNC_RESET = 7'h43;

  typedef enum {I2C_IDLE, I2C_RECV, I2C_ACK, I2C_SEND, I2C_MACK} i2c_state_type;
  typedef enum {P_INIT, P_LOW, P_WAKE, P_FULL} power_state_type;
endpackage

//--- rtl/mgmt_timing.sv
// Management sequencing: init, reset filter, flags, interrupt, power modes, 2-wire access
//
// Contract
// - Management init completes within 2000 ms of power-on, insertion or reset release.
// - Reset low for at least 10 us always starts a reset sequence.
// - Interrupt output goes low within 200 ms of an interrupting condition.
// - Flags clear on read; interrupt releases within 500 us of that read.
// - Receive loss sets its flag and pulls interrupt low within 100 ms.
// - Any flag condition sets its flag and asserts interrupt within 200 ms.
// - Setting a mask bit inhibits that flag's interrupt within 100 ms.
// - Clearing a mask bit lets that flag interrupt again within 100 ms.
// - Fully functional within 2 s of power-on when low power not requested.
// - The 2-wire bus answers within 2 s of power-on.
// - Data-not-ready bit clears and interrupt asserts within 2 s of power-on.
// - After reset rising edge, fully functional again within 2 s.
// - Shared low-power / transmit-disable input changes function within 100 ms.
// - Low-power input high brings power to class 1 within 100 ms.
// - Low-power input low brings full function within 300 ms.
// - Shared interrupt / receive-loss output changes function within 100 ms.
// - Power override or power set bit high gives class 1 within 100 ms.
// - Power override and set bits cleared give full function within 300 ms.
// - Register access runs over a 2-wire bus of clock and data lines.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
module mgmt_timing import mgmt_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int INIT_TICKS_P = INIT_TICKS
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic module_reset_n,
  input wire logic low_power_in,
  input wire logic rx_los_in,
  input wire logic tx_fault_in,
  input wire logic aux_alarm_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic irq_out_n,
  output logic tx_disable_out,
  output logic mgmt_init_state,
  output logic low_power_state,
  output logic fully_functional
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [6:0] meta;
  logic [6:0] sync;
  logic scl_p;
  logic sda_p;
  logic rst_n_s, lp_s, rx_los_s, tx_fault_s, aux_s, scl_s, sda_s;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= SYNC_RESET;
      sync <= SYNC_RESET;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      meta <= {module_reset_n, low_power_in, rx_los_in, tx_fault_in, aux_alarm_in, scl_in, sda_in};
      sync <= meta;
      scl_p <= sync[1];
      sda_p <= sync[0];
    end
  end

  assign {rst_n_s, lp_s, rx_los_s, tx_fault_s, aux_s, scl_s, sda_s} = sync;

  // ****************************************
  // Free-running time base
  // ****************************************
  logic [15:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == 16'(TICK_CYCLES_P - 1));

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 16'h0000;
    end else if (tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // ****************************************
  // Module reset pulse filter
  // ****************************************
  // Pulses shorter than the minimum are dropped on purpose to ride out glitches
  logic [9:0] low_cnt;
  logic reset_armed;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt <= 10'h000;
      reset_armed <= 1'b0;
    end else if (!rst_n_s) begin
      if (low_cnt != 10'(RESET_MIN_CYCLES)) begin
        low_cnt <= low_cnt + 10'h001;
      end
      if (low_cnt == 10'(RESET_MIN_CYCLES - 1)) begin
        reset_armed <= 1'b1;
      end
    end else begin
      low_cnt <= 10'h000;
      reset_armed <= 1'b0;
    end
  end

  // ****************************************
  // Power and init sequencing
  // ****************************************
  power_state_type pstate;
  logic [15:0] cnt;
  logic [3:0] mask;
  logic [3:0] ctrl;
  logic [3:0] flags;
  logic lp_req;
  logic init_end;

  assign lp_req = (!ctrl[CTRL_PIN_LASER_OFF] && lp_s) || ctrl[CTRL_PWR_OVR] || ctrl[CTRL_PWR_SET];
  assign init_end = (pstate == P_INIT) && tick && !reset_armed && (cnt == 16'(INIT_TICKS_P - 1));
  assign mgmt_init_state = (pstate == P_INIT);
  assign low_power_state = (pstate == P_LOW);
  assign fully_functional = (pstate == P_FULL);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pstate <= P_INIT;
      cnt <= 16'h0000;
    end else if (reset_armed) begin
      pstate <= P_INIT;
      cnt <= 16'h0000;
    end else begin
      case (pstate)
        P_INIT: begin
          if (init_end) begin
            pstate <= lp_req ? P_LOW : P_FULL;
            cnt <= 16'h0000;
          end else if (tick) begin
            cnt <= cnt + 16'h0001;
          end
        end
        P_LOW: begin
          if (!lp_req) begin
            pstate <= P_WAKE;
            cnt <= 16'h0000;
          end
        end
        P_WAKE: begin
          if (lp_req) begin
            pstate <= P_LOW;
          end else if (tick) begin
            if (cnt == 16'(WAKE_TICKS - 1)) begin
              pstate <= P_FULL;
            end
            cnt <= cnt + 16'h0001;
          end
        end
        P_FULL: begin
          if (lp_req) begin
            pstate <= P_LOW;
          end
        end
        default: begin
          pstate <= P_INIT;
        end
      endcase
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      STATUS_ADDR: v[NOT_READY_BIT] = mgmt_init_state;
      FLAGS_ADDR: v[3:0] = flags;
      MASK_ADDR: v[3:0] = mask;
      CTRL_ADDR: v[3:0] = ctrl;
      STATE_ADDR: v[2:0] = {mgmt_init_state, low_power_state, fully_functional};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  i2c_state_type istate;
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [7:0] byte_in;
  logic [7:0] rd_val;
  logic i2c_wr;
  logic i2c_load;
  logic wr_en;
  logic [7:0] wr_a;
  logic [7:0] wr_d;
  logic rd_flags;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic pending;

  assign wr_en = reg_write || i2c_wr;
  assign wr_a = reg_write ? reg_addr : ptr;
  assign wr_d = reg_write ? reg_wdata : byte_in;
  // Process form so a register change refreshes the byte while the pointer holds still
  always_comb begin
    rd_val = read_reg(ptr);
  end
  assign rd_flags = (reg_read && reg_addr == FLAGS_ADDR) || (i2c_load && ptr == FLAGS_ADDR);
  assign flag_clr = rd_flags ? flags : 4'h0;
  assign flag_set = {init_end, {3{!mgmt_init_state}} & {aux_s, tx_fault_s, rx_los_s}};
  assign pending = |(flags & ~mask);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mask <= MASK_RESET;
      ctrl <= CTRL_RESET;
    end else if (reset_armed) begin
      mask <= MASK_RESET;
      ctrl <= CTRL_RESET;
    end else if (wr_en) begin
      if (wr_a == MASK_ADDR) begin
        mask <= wr_d[3:0];
      end
      if (wr_a == CTRL_ADDR) begin
        ctrl <= wr_d[3:0];
      end
    end
  end

  // A new event in the clearing cycle survives: set wins over clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flags <= 4'h0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? read_reg(reg_addr) : 8'h00;
    end
  end

  // ****************************************
  // Shared pins
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_out_n <= 1'b1;
      tx_disable_out <= 1'b0;
    end else begin
      irq_out_n <= ctrl[CTRL_PIN_RXLOS] ? !rx_los_s : !pending;
      tx_disable_out <= ctrl[CTRL_PIN_LASER_OFF] && lp_s;
    end
  end

  // ****************************************
  // 2-wire management slave
  // ****************************************
  // Held idle through init so the host never sees a half-ready device
  logic [2:0] bcnt;
  logic [1:0] phase;
  logic is_rd;
  logic acking;
  logic scl_r, scl_f, start_c, stop_c;

  assign scl_r = scl_s && !scl_p;
  assign scl_f = !scl_s && scl_p;
  assign start_c = scl_s && scl_p && sda_p && !sda_s;
  assign stop_c = scl_s && scl_p && !sda_p && sda_s;
  assign byte_in = {sh[6:0], sda_s};
  assign sda_out = 1'b0;
  assign i2c_wr = (istate == I2C_RECV) && scl_r && (bcnt == 3'h7) && (phase == 2'h2) && !reg_write;
  assign i2c_load = scl_f && acking && ((istate == I2C_ACK && is_rd) || istate == I2C_MACK);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      istate <= I2C_IDLE;
      sh <= 8'h00;
      ptr <= 8'h00;
      bcnt <= 3'h0;
      phase <= 2'h0;
      is_rd <= 1'b0;
      acking <= 1'b0;
      sda_oe <= 1'b0;
    end else if (mgmt_init_state || stop_c) begin
      istate <= I2C_IDLE;
      acking <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      istate <= I2C_RECV;
      bcnt <= 3'h0;
      phase <= 2'h0;
      is_rd <= 1'b0;
      acking <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (istate)
        I2C_IDLE: begin
          sda_oe <= 1'b0;
        end
        I2C_RECV: begin
          if (scl_r) begin
            sh <= byte_in;
            bcnt <= bcnt + 3'h1;
            if (bcnt == 3'h7) begin
              if (phase == 2'h0 && byte_in[7:1] != DEV_ADDR) begin
                istate <= I2C_IDLE;
              end else begin
                istate <= I2C_ACK;
                if (phase == 2'h0) begin
                  is_rd <= byte_in[0];
                end
                if (phase == 2'h1) begin
                  ptr <= byte_in;
                end
                if (phase == 2'h2) begin
                  ptr <= ptr + 8'h01;
                end else begin
                  phase <= phase + 2'h1;
                end
              end
            end
          end
        end
        I2C_ACK: begin
          if (scl_f) begin
            if (!acking) begin
              acking <= 1'b1;
              sda_oe <= 1'b1;
            end else begin
              acking <= 1'b0;
              bcnt <= 3'h0;
              if (is_rd) begin
                istate <= I2C_SEND;
                sh <= rd_val;
                ptr <= ptr + 8'h01;
                sda_oe <= !rd_val[7];
              end else begin
                istate <= I2C_RECV;
                sda_oe <= 1'b0;
              end
            end
          end
        end
        I2C_SEND: begin
          if (scl_f) begin
            if (bcnt == 3'h7) begin
              istate <= I2C_MACK;
              sda_oe <= 1'b0;
            end else begin
              sh <= {sh[6:0], 1'b0};
              sda_oe <= !sh[6];
              bcnt <= bcnt + 3'h1;
            end
          end
        end
        I2C_MACK: begin
          if (scl_r) begin
            if (sda_s) begin
              istate <= I2C_IDLE;
            end else begin
              acking <= 1'b1;
            end
          end else if (i2c_load) begin
            istate <= I2C_SEND;
            acking <= 1'b0;
            bcnt <= 3'h0;
            sh <= rd_val;
            ptr <= ptr + 8'h01;
            sda_oe <= !rd_val[7];
          end
        end
        default: begin
          istate <= I2C_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [15:0] init_age;
  logic [15:0] wake_age;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      init_age <= 16'h0000;
      wake_age <= 16'h0000;
    end else begin
      if (!mgmt_init_state || reset_armed || !rst_n_s) begin
        init_age <= 16'h0000;
      end else if (tick) begin
        init_age <= init_age + 16'h0001;
      end
      if (fully_functional || lp_req || mgmt_init_state) begin
        wake_age <= 16'h0000;
      end else if (tick) begin
        wake_age <= wake_age + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_release;
    reset_armed && rst_n_s;
  endsequence

  sequence s_flag_read;
    reg_read && reg_addr == FLAGS_ADDR && !ctrl[CTRL_PIN_RXLOS];
  endsequence

  tick_period_a: assert property (tick |=> tick_cnt == 16'h0000 ##1 !tick)
    else $error("time base tick not periodic");
  reset_accept_a: assert property ((!rst_n_s && low_cnt == 10'(RESET_MIN_CYCLES - 1)) |=> reset_armed)
    else $error("long reset pulse not accepted");
  reset_restart_a: assert property (s_release |=> mgmt_init_state ##1 mgmt_init_state)
    else $error("reset release did not restart init");
  init_bound_a: assert property (mgmt_init_state |-> init_age < 16'(INIT_LIMIT_TICKS))
    else $error("init exceeded its deadline");
  ready_clear_a: assert property (init_end |=> !mgmt_init_state && flags[FLAG_INIT_DONE])
    else $error("not ready bit or init flag wrong at init end");
  bus_quiet_a: assert property (mgmt_init_state |=> istate == I2C_IDLE && !sda_oe)
    else $error("2-wire slave active during init");
  los_flag_a: assert property ((rx_los_s && !mgmt_init_state) |=> flags[FLAG_RX_LOSS])
    else $error("receive loss flag not set");
  irq_assert_a: assert property ((!ctrl[CTRL_PIN_RXLOS] && pending) |=> !irq_out_n)
    else $error("pending flag did not pull interrupt low");
  irq_release_a: assert property (s_flag_read ##1 (!ctrl[CTRL_PIN_RXLOS] && !pending) |=> irq_out_n)
    else $error("interrupt not released after clearing read");
  mask_inhibit_a: assert property ((!ctrl[CTRL_PIN_RXLOS] && flags != 4'h0 && !pending) |=> irq_out_n)
    else $error("masked flag still drives interrupt");
  pin_mode_a: assert property (ctrl[CTRL_PIN_RXLOS] |=> irq_out_n == !$past(rx_los_s))
    else $error("shared output not in receive loss mode");
  power_down_a: assert property ((lp_req && !mgmt_init_state && !reset_armed) |=> low_power_state)
    else $error("low power request not honoured");
  wake_bound_a: assert property (wake_age <= 16'(WAKE_LIMIT_TICKS))
    else $error("wake from low power too slow");
endmodule

//--- bench/host_link_model.sv
// Behavioural host controller for the 2-wire management link
`timescale 1ns/100ps
module host_link_model import mgmt_pkg::*; (
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  // ****************************************
  // Bit and frame timing, 160 ns link clock
  // ****************************************
  // Clock rests high and data is released between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Data moves mid-low so the device never sees it beside a clock edge
  task automatic put(input logic b);
    #40 sda_pull = !b;
    #40 scl = 1'b1;
    #80 scl = 1'b0;
  endtask

  // Sampled mid-high: the device updates data a few cycles after the fall
  task automatic get(output logic b);
    #40 sda_pull = 1'b0;
    #40 scl = 1'b1;
    #40 b = sda_line;
    #40 scl = 1'b0;
  endtask

  task automatic start;
    #40 sda_pull = 1'b0;
    #40 scl = 1'b1;
    #40 sda_pull = 1'b1;
    #40 scl = 1'b0;
  endtask

  task automatic stop;
    #40 sda_pull = 1'b1;
    #40 scl = 1'b1;
    #40 sda_pull = 1'b0;
  endtask

  task automatic send(input logic [7:0] d, inout logic nak);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    nak = nak | a;
  endtask

  // Pointer write, repeated start, one byte read, closed by a not-acknowledge
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic nak);
    nak = 1'b0;
    start;
    send({DEV_ADDR, 1'b0}, nak);
    send(ptr, nak);
    start;
    send({DEV_ADDR, 1'b1}, nak);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop;
  endtask
endmodule

//--- bench/pluggable_module_mgmt_timing_tb.sv
// Self-checking testbench for the management timing block
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("CHECK FAILED at %0t ns: got %h expected %h", $time, (got), (exp)); \
  end \
end
module pluggable_module_mgmt_timing_tb import mgmt_pkg::*;;
  // Short time base keeps the long power-mode waits affordable
  localparam int TK = 4;
  localparam int IT = 3;
  localparam int INIT_WAIT = IT * TK + 20;
  localparam int WAKE_WAIT = WAKE_TICKS * TK + 20;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic module_reset_n = 1'b1;
  logic low_power_in = 1'b0;
  logic [2:0] cond = 3'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  logic irq_out_n;
  logic tx_disable_out;
  logic mgmt_init_state;
  logic low_power_state;
  logic fully_functional;
  wire sda_line;
  int n_errors = 0;
  int n_tests = 0;

  always #10 clock = ~clock;
  // Open-drain data line with pull-up
  assign sda_line = !(sda_pull | sda_oe);

  mgmt_timing #(.TICK_CYCLES_P(TK), .INIT_TICKS_P(IT)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .module_reset_n(module_reset_n),
    .low_power_in(low_power_in), .rx_los_in(cond[0]), .tx_fault_in(cond[1]),
    .aux_alarm_in(cond[2]), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq_out_n(irq_out_n),
    .tx_disable_out(tx_disable_out), .mgmt_init_state(mgmt_init_state),
    .low_power_state(low_power_state), .fully_functional(fully_functional)
  );

  host_link_model i_host (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  task automatic settle;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic wait_ff(input int lim);
    int k;
    k = 0;
    while (fully_functional !== 1'b1 && k < lim) begin
      @(posedge clock);
      #1;
      k++;
    end
    `CHK(fully_functional, 1'b1)
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [7:0] d;
    logic nak;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    `CHK(mgmt_init_state, 1'b1)
    rchk(STATUS_ADDR, 8'h01);
    wait_ff(INIT_WAIT);
    settle;
    `CHK(irq_out_n, 1'b0)
    rchk(STATUS_ADDR, 8'h00);
    rchk(FLAGS_ADDR, 8'h08);
    settle;
    `CHK(irq_out_n, 1'b1)
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      cond <= 3'h1 << i;
      settle;
      `CHK(irq_out_n, 1'b0)
      @(posedge clock);
      cond <= 3'h0;
      settle;
      rchk(FLAGS_ADDR, 8'h01 << i);
      rchk(FLAGS_ADDR, 8'h00);
      settle;
      `CHK(irq_out_n, 1'b1)
    end
    wr(MASK_ADDR, 8'h02);
    @(posedge clock);
    cond <= 3'h2;
    settle;
    `CHK(irq_out_n, 1'b1)
    rchk(MASK_ADDR, 8'h02);
    wr(MASK_ADDR, 8'h00);
    settle;
    `CHK(irq_out_n, 1'b0)
    @(posedge clock);
    cond <= 3'h0;
    settle;
    rchk(FLAGS_ADDR, 8'h02);
    rchk(FLAGS_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h08);
    @(posedge clock);
    cond <= 3'h1;
    settle;
    `CHK(irq_out_n, 1'b0)
    @(posedge clock);
    cond <= 3'h0;
    settle;
    `CHK(irq_out_n, 1'b1)
    wr(CTRL_ADDR, 8'h00);
    settle;
    `CHK(irq_out_n, 1'b0)
    rchk(FLAGS_ADDR, 8'h01);
    settle;
    `CHK(irq_out_n, 1'b1)
    wr(CTRL_ADDR, 8'h04);
    @(posedge clock);
    low_power_in <= 1'b1;
    settle;
    `CHK(tx_disable_out, 1'b1)
    `CHK(low_power_state, 1'b0)
    @(posedge clock);
    low_power_in <= 1'b0;
    settle;
    `CHK(tx_disable_out, 1'b0)
    wr(CTRL_ADDR, 8'h00);
    @(posedge clock);
    low_power_in <= 1'b1;
    settle;
    `CHK(low_power_state, 1'b1)
    `CHK(fully_functional, 1'b0)
    @(posedge clock);
    low_power_in <= 1'b0;
    wait_ff(WAKE_WAIT);
    for (int i = 0; i < 2; i++) begin
      wr(CTRL_ADDR, 8'h01 << i);
      settle;
      `CHK(low_power_state, 1'b1)
      wr(CTRL_ADDR, 8'h00);
      wait_ff(WAKE_WAIT);
    end
    wr(MASK_ADDR, 8'h0F);
    @(posedge clock);
    module_reset_n <= 1'b0;
    repeat (RESET_MIN_CYCLES + 10) @(posedge clock);
    #1;
    `CHK(mgmt_init_state, 1'b1)
    @(posedge clock);
    module_reset_n <= 1'b1;
    wait_ff(INIT_WAIT);
    rchk(MASK_ADDR, 8'h00);
    rchk(FLAGS_ADDR, 8'h08);
    rchk(8'h7F, 8'h00);
    settle;
    i_host.read_reg(STATE_ADDR, d, nak);
    `CHK(nak, 1'b0)
    `CHK(d, 8'h01)
    `CHK(sda_out, 1'b0)
    print_verdict;
  end

  // Whole run is about 25000 cycles
  initial begin
    #1000000;
    n_errors++;
    print_verdict;
  end
endmodule
